// ==== rtl/sdc_divider_regs.sv ====
/*
  Divider and gain configuration bank, registers 1 to 7, written over the
  three-wire serial port. Assumes the host shifts 18 data bits MSB first,
  then 4 address bits MSB first, on rising serial clock edges while the
  enable is low, and ends the word by raising the enable.
*/
// Behaviour
// - Address 1 holds IF gain in 5:4, band B in 3:2, band A in 1:0.
// - Address 2: bit 1 IF synth on when set, bit 0 RF synth on when set.
// - Address 3 holds the 18-bit band A feedback divide value.
// - Address 4 holds the 17-bit band B feedback divide value in 16:0.
// - Address 7 holds the 13-bit band B reference divide value in 12:0.
`timescale 1ns/1ps
`default_nettype none
module sdc_divider_regs
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Three-wire serial port.
  input wire logic serClk,
  input wire logic serData,
  input wire logic serEnable_n,
  // Loop gain codes.
  output logic [1:0] ifGainCode,
  output logic [1:0] bandBGainCode,
  output logic [1:0] bandAGainCode,
  // Synthesizer power, high means powered up.
  output logic ifSynthOnN,
  output logic rfSynthOnN,
  // Divider values.
  output logic [17:0] bandAFeedbackValue,
  output logic [16:0] bandBFeedbackValue,
  output logic [15:0] ifFeedbackValue,
  output logic [12:0] bandAReferenceValue,
  output logic [12:0] bandBReferenceValue,
  // Word status pulses.
  output logic wordAccepted,
  output logic wordRejected
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  logic [2:0] clkSync_ff;
  logic [1:0] dataSync_ff;
  logic [2:0] enSync_ff;
  logic clkRise;
  logic enRise;
  logic enFall;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      clkSync_ff <= 3'h0;
      dataSync_ff <= 2'h0;
      enSync_ff <= 3'h7;
    end
    else
    begin
      clkSync_ff <= {clkSync_ff[1:0], serClk};
      dataSync_ff <= {dataSync_ff[0], serData};
      enSync_ff <= {enSync_ff[1:0], serEnable_n};
    end
  end

  // Edges are taken only between the second and third stages.
  assign clkRise = clkSync_ff[1] & ~clkSync_ff[2];
  assign enRise = enSync_ff[1] & ~enSync_ff[2];
  assign enFall = ~enSync_ff[1] & enSync_ff[2];

  //////////////////////////////////////////////////////////////////////////////
  // Word shifter and bit counter.
  logic [21:0] shift_ff;
  logic [4:0] bitCnt_ff;
  logic commit;
  logic [17:0] wordData;
  logic [3:0] wordAddr;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      shift_ff <= 22'h000000;
      bitCnt_ff <= 5'h00;
    end
    else if (enFall)
    begin
      bitCnt_ff <= 5'h00;
    end
    else if (clkRise && !enSync_ff[1])
    begin
      shift_ff <= {shift_ff[20:0], dataSync_ff[1]};
      if (bitCnt_ff != sdc_pkg::CNT_MAX)
        bitCnt_ff <= bitCnt_ff + 5'h01;
    end
  end

  // A word that is short or long is dropped whole rather than half applied.
  assign commit = enRise && (bitCnt_ff == sdc_pkg::WORD_BITS);
  assign wordData = shift_ff[21:4];
  assign wordAddr = shift_ff[3:0];

  function automatic logic sdcListed(input logic [3:0] addr);
    sdcListed = (addr >= sdc_pkg::ADDR_GAIN) &&
      (addr <= sdc_pkg::ADDR_BAND_B_REF);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Word status.
  logic accepted_ff;
  logic rejected_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      accepted_ff <= 1'h0;
      rejected_ff <= 1'h0;
    end
    else
    begin
      accepted_ff <= commit && sdcListed(wordAddr);
      // Writes outside the bank are ignored so they cannot disturb it.
      rejected_ff <= enRise && !(commit && sdcListed(wordAddr));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bank. Reserved bits are not stored.
  logic [1:0] ifGain_ff;
  logic [1:0] bandBGain_ff;
  logic [1:0] bandAGain_ff;
  logic ifOn_ff;
  logic rfOn_ff;
  logic [17:0] bandAFb_ff;
  logic [16:0] bandBFb_ff;
  logic [15:0] ifFb_ff;
  logic [12:0] bandARef_ff;
  logic [12:0] bandBRef_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ifGain_ff <= sdc_pkg::RST_GAIN;
      bandBGain_ff <= sdc_pkg::RST_GAIN;
      bandAGain_ff <= sdc_pkg::RST_GAIN;
    end
    else if (commit && wordAddr == sdc_pkg::ADDR_GAIN)
    begin
      ifGain_ff <= wordData[sdc_pkg::GAIN_IF_LSB +: sdc_pkg::GAIN_W];
      bandBGain_ff <= wordData[sdc_pkg::GAIN_B_LSB +: sdc_pkg::GAIN_W];
      bandAGain_ff <= wordData[sdc_pkg::GAIN_A_LSB +: sdc_pkg::GAIN_W];
    end
  end

  // Both synthesizers come out of reset powered down until software acts.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ifOn_ff <= sdc_pkg::RST_POWER;
      rfOn_ff <= sdc_pkg::RST_POWER;
    end
    else if (commit && wordAddr == sdc_pkg::ADDR_POWER)
    begin
      ifOn_ff <= wordData[sdc_pkg::POWER_IF_BIT];
      rfOn_ff <= wordData[sdc_pkg::POWER_RF_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bandAFb_ff <= sdc_pkg::RST_BAND_A_FB;
    else if (commit && wordAddr == sdc_pkg::ADDR_BAND_A_FB)
      bandAFb_ff <= wordData[sdc_pkg::BAND_A_FB_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bandBFb_ff <= sdc_pkg::RST_BAND_B_FB;
    else if (commit && wordAddr == sdc_pkg::ADDR_BAND_B_FB)
      bandBFb_ff <= wordData[sdc_pkg::BAND_B_FB_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ifFb_ff <= sdc_pkg::RST_IF_FB;
    else if (commit && wordAddr == sdc_pkg::ADDR_IF_FB)
      ifFb_ff <= wordData[sdc_pkg::IF_FB_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bandARef_ff <= sdc_pkg::RST_REF;
    else if (commit && wordAddr == sdc_pkg::ADDR_BAND_A_REF)
      bandARef_ff <= wordData[sdc_pkg::REF_W-1:0];
  end

  // Range limits on the reference value are left to the host.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bandBRef_ff <= sdc_pkg::RST_REF;
    else if (commit && wordAddr == sdc_pkg::ADDR_BAND_B_REF)
      bandBRef_ff <= wordData[sdc_pkg::REF_W-1:0];
  end

  assign ifGainCode = ifGain_ff;
  assign bandBGainCode = bandBGain_ff;
  assign bandAGainCode = bandAGain_ff;
  assign ifSynthOnN = ifOn_ff;
  assign rfSynthOnN = rfOn_ff;
  assign bandAFeedbackValue = bandAFb_ff;
  assign bandBFeedbackValue = bandBFb_ff;
  assign ifFeedbackValue = ifFb_ff;
  assign bandAReferenceValue = bandARef_ff;
  assign bandBReferenceValue = bandBRef_ff;
  assign wordAccepted = accepted_ff;
  assign wordRejected = rejected_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence sWrite(logic [3:0] addr);
    commit && wordAddr == addr;
  endsequence

  chk_gain_load: assert property (
    sWrite(sdc_pkg::ADDR_GAIN) |=>
      {ifGain_ff, bandBGain_ff, bandAGain_ff} == $past(wordData[5:0]))
    else $error("gain codes not loaded from write");

  chk_gain_hold: assert property (
    !(commit && wordAddr == sdc_pkg::ADDR_GAIN) |=>
      $stable({ifGain_ff, bandBGain_ff, bandAGain_ff}))
    else $error("gain code changed without gain write");

  chk_power_load: assert property (
    sWrite(sdc_pkg::ADDR_POWER) |=>
      {ifSynthOnN, rfSynthOnN} == $past(wordData[1:0]))
    else $error("power bits not loaded from write");

  chk_band_a_fb: assert property (
    sWrite(sdc_pkg::ADDR_BAND_A_FB) |=>
      bandAFeedbackValue == $past(wordData))
    else $error("band A feedback value wrong");

  chk_band_b_fb: assert property (
    sWrite(sdc_pkg::ADDR_BAND_B_FB) |=>
      bandBFeedbackValue == $past(wordData[16:0]))
    else $error("band B feedback value wrong");

  chk_band_b_ref: assert property (
    sWrite(sdc_pkg::ADDR_BAND_B_REF) |=>
      bandBReferenceValue == $past(wordData[12:0]) && wordAccepted)
    else $error("band B reference value wrong");

  chk_ref_hold: assert property (
    !(commit && wordAddr == sdc_pkg::ADDR_BAND_B_REF) |=>
      $stable(bandBReferenceValue))
    else $error("band B reference changed without write");

  chk_short_drop: assert property (
    enRise && bitCnt_ff != sdc_pkg::WORD_BITS |=>
      wordRejected && $stable(bandAFeedbackValue))
    else $error("malformed word was applied");

endmodule // sdc_divider_regs
`default_nettype wire

// ==== pkg/sdc_pkg.sv ====
/*
  Constants for the synthesizer divider configuration bank: word layout of
  the serial port, register addresses, field positions and reset values.
  Assumes a single 18-bit data plus 4-bit address word per write.
*/
`default_nettype none
package sdc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Serial word layout.
  localparam int DATA_W = 18;
  localparam int ADDR_W = 4;
  localparam int WORD_W = 22;
  localparam logic [4:0] WORD_BITS = 5'h16;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  ////////////////////////////////////////////////////////////////////////////
  // Register addresses.
  localparam logic [3:0] ADDR_GAIN = 4'h1;
  localparam logic [3:0] ADDR_POWER = 4'h2;
  localparam logic [3:0] ADDR_BAND_A_FB = 4'h3;
  localparam logic [3:0] ADDR_BAND_B_FB = 4'h4;
  localparam logic [3:0] ADDR_IF_FB = 4'h5;
  localparam logic [3:0] ADDR_BAND_A_REF = 4'h6;
  localparam logic [3:0] ADDR_BAND_B_REF = 4'h7;
  ////////////////////////////////////////////////////////////////////////////
  // Field positions and widths.
  localparam int GAIN_IF_LSB = 4;
  localparam int GAIN_B_LSB = 2;
  localparam int GAIN_A_LSB = 0;
  localparam int GAIN_W = 2;
  localparam int POWER_IF_BIT = 1;
  localparam int POWER_RF_BIT = 0;
  localparam int BAND_A_FB_W = 18;
  localparam int BAND_B_FB_W = 17;
  localparam int IF_FB_W = 16;
  localparam int REF_W = 13;
  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [1:0] RST_GAIN = 2'h0;
  localparam logic RST_POWER = 1'h0;
  localparam logic [17:0] RST_BAND_A_FB = 18'h00000;
  localparam logic [16:0] RST_BAND_B_FB = 17'h00000;
  localparam logic [15:0] RST_IF_FB = 16'h0000;
  localparam logic [12:0] RST_REF = 13'h0000;
endpackage
`default_nettype wire

// ==== verification/sdc_host_model.sv ====
/*
  Host controller model that writes words over the three-wire serial port.
  Assumes the bench raises go for one cycle just after a rising mclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model
(
  // Clock and request.
  input wire logic mclk,
  input wire logic go,
  input wire logic [21:0] word,
  input wire logic [4:0] nbits,
  input wire logic [3:0] halfCyc,
  // Serial pins and busy flag.
  output logic serClk,
  output logic serData,
  output logic serEnable_n,
  output logic busy
);
  initial
  begin
    serClk = 1'b0;
    serData = 1'b0;
    serEnable_n = 1'b1;
    busy = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // The serial clock stands still outside frames, and released data flips.
  always
  begin
    @(posedge mclk);
    if (go === 1'b1)
    begin
      #1 busy = 1'b1;
      serEnable_n = 1'b0;
      repeat (halfCyc) @(posedge mclk);
      for (int i = 0; i < nbits; i++)
      begin
        #1 serData = word[21 - i];
        repeat (halfCyc) @(posedge mclk);
        #1 serClk = 1'b1;
        repeat (halfCyc) @(posedge mclk);
        #1 serClk = 1'b0;
        repeat (halfCyc) @(posedge mclk);
      end
      #1 serEnable_n = 1'b1;
      serData = ~serData;
      repeat (halfCyc) @(posedge mclk);
      #1 busy = 1'b0;
    end
  end
endmodule // sdc_host_model
`default_nettype wire

// ==== verification/sdc_divider_regs_tb.sv ====
/*
  Self-checking bench for the divider bank, driving it through the host model.
  Assumes a 20 MHz mclk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_divider_regs_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [21:0] word = 22'h000000;
  logic [4:0] nbits = 5'h16;
  logic [3:0] halfCyc = 4'h3;
  logic serClk, serData, serEnable_n, busy;
  logic [1:0] ifGainCode, bandBGainCode, bandAGainCode;
  logic ifSynthOnN, rfSynthOnN, wordAccepted, wordRejected;
  logic [17:0] bandAFeedbackValue;
  logic [16:0] bandBFeedbackValue;
  logic [15:0] ifFeedbackValue;
  logic [12:0] bandAReferenceValue, bandBReferenceValue;
  logic [17:0] expReg [1:7];
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'haa33982c;
  always #25 mclk = ~mclk;
  sdc_host_model host (.mclk(mclk), .go(go), .word(word), .nbits(nbits),
    .halfCyc(halfCyc), .serClk(serClk), .serData(serData),
    .serEnable_n(serEnable_n), .busy(busy));
  sdc_divider_regs DUT (.mclk(mclk), .rst_n(rst_n), .serClk(serClk),
    .serData(serData), .serEnable_n(serEnable_n), .ifGainCode(ifGainCode),
    .bandBGainCode(bandBGainCode), .bandAGainCode(bandAGainCode),
    .ifSynthOnN(ifSynthOnN), .rfSynthOnN(rfSynthOnN),
    .bandAFeedbackValue(bandAFeedbackValue),
    .bandBFeedbackValue(bandBFeedbackValue),
    .ifFeedbackValue(ifFeedbackValue),
    .bandAReferenceValue(bandAReferenceValue),
    .bandBReferenceValue(bandBReferenceValue),
    .wordAccepted(wordAccepted), .wordRejected(wordRejected));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] fieldMask(input int a);
    case (a)
      1: return 18'h0003f;
      2: return 18'h00003;
      3: return 18'h3ffff;
      4: return 18'h1ffff;
      5: return 18'h0ffff;
      default: return 18'h01fff;
    endcase
  endfunction
  function automatic logic [17:0] seen(input int a);
    case (a)
      1: return {12'h000, ifGainCode, bandBGainCode, bandAGainCode};
      2: return {16'h0000, ifSynthOnN, rfSynthOnN};
      3: return bandAFeedbackValue;
      4: return {1'h0, bandBFeedbackValue};
      5: return {2'h0, ifFeedbackValue};
      6: return {5'h00, bandAReferenceValue};
      default: return {5'h00, bandBReferenceValue};
    endcase
  endfunction
  // Breakpoints double from the loop's lowest one.
  function automatic logic [1:0] gainFor(input logic [17:0] v, input int bp);
    if (v < bp) return 2'h0;
    if (v < 2 * bp) return 2'h1;
    if (v < 4 * bp) return 2'h2;
    return 2'h3;
  endfunction
  function automatic int minRef(input logic [1:0] g);
    return (g == 2'h0) ? 7 : (g == 2'h1) ? 8 : (g == 2'h2) ? 10 : 14;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic checkVal(input string name, input logic [17:0] exp,
    input logic [17:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic checkBit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic checkAll;
    for (int a = 1; a <= 7; a++)
      checkVal($sformatf("reg%0d", a), expReg[a],
        seen(a));
  endtask
  // Entered and left just after a rising edge.
  task automatic writeWord(input int a, input logic [17:0] d,
    input logic [4:0] n);
    logic acc;
    logic rej;
    logic good;
    acc = 1'b0;
    rej = 1'b0;
    good = (n == 5'h16) && (a >= 1) && (a <= 7);
    word = {d, a[3:0]};
    nbits = n;
    go = 1'b1;
    @(posedge mclk);
    #1 go = 1'b0;
    for (int k = 0; k < 3000 && !(acc || rej); k++)
    begin
      @(posedge mclk);
      #2 acc = (wordAccepted === 1'b1);
      rej = (wordRejected === 1'b1);
    end
    checkBit("accepted", good, acc);
    checkBit("rejected", !good, rej);
    @(posedge mclk);
    #2 checkBit("pulse end", 1'b0, wordAccepted | wordRejected);
    if (good)
      expReg[a] = d & fieldMask(a);
    while (busy === 1'b1)
      @(posedge mclk);
    @(posedge mclk);
    #1 checkAll();
  endtask
  task automatic print_verdict;
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    int v;
    for (int a = 1; a <= 7; a++)
      expReg[a] = 18'h00000;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge mclk);
    #1 checkAll();
    $display("Test reset done");
    // Slower serial timing is mixed in to stretch every phase of a word.
    for (int r = 0; r < 4; r++)
    begin
      halfCyc = 4'h3 + 4'($unsigned($random(seed)) % 3);
      for (int a = 3; a <= 6; a++)
        writeWord(a, 18'($random(seed)) & fieldMask(a), 5'h16);
      writeWord(1, {12'h000, gainFor(expReg[5], 2048),
        gainFor(expReg[4], 4096),
        gainFor(expReg[3], 8192)}, 5'h16);
      v = minRef(expReg[1][3:2]);
      v = v + int'($unsigned($random(seed)) % (8190 - v));
      writeWord(7, 18'(v), 5'h16);
      writeWord(2, 18'($random(seed)) & 18'h00003, 5'h16);
    end
    $display("Test random done");
    writeWord(3, 18'h3ffff, 5'h16);
    writeWord(4, 18'h3ffff, 5'h16);
    writeWord(7, 18'h3fffd, 5'h16);
    writeWord(2, 18'h3fffe, 5'h16);
    $display("Test limits done");
    // A reset in mid-run must clear every value the writes above left.
    rst_n = 1'b0;
    for (int a = 1; a <= 7; a++)
      expReg[a] = 18'h00000;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge mclk);
    #1 checkAll();
    $display("Test mid reset done");
    for (int a = 8; a <= 16; a++)
      writeWord(a & 15, 18'h15555, 5'h16);
    writeWord(3, 18'h0aaaa, 5'h15);
    $display("Test refused done");
    print_verdict();
  end
endmodule // sdc_divider_regs_tb
`default_nettype wire
